/* logic/rco_pkg.sv */
// constants, field layout and carrier types of the reference clock control
// assumes a single pclk domain and a 32-bit APB register bus
package rco_pkg;

    // ****************************************
    // bus and register map
    // ****************************************
    localparam int              RCO_ADDR_W   = 12;
    localparam int              RCO_DATA_W   = 32;
    localparam logic [11:0]     RCO_CTRL_OFF = 12'h000;

    // ****************************************
    // control register fields
    // ****************************************
    localparam int              RCO_DIV_LSB  = 16;
    localparam int              RCO_DIV_W    = 15;
    localparam int              RCO_ON_BIT   = 15;
    localparam int              RCO_STOP_IN_IDLE_BIT = 13;
    localparam int              RCO_OE_BIT   = 12;
    localparam int              RCO_RUN_IN_SLEEP_BIT = 11;
    localparam int              RCO_SWGO_BIT = 9;
    localparam int              RCO_ACT_BIT  = 8;
    localparam int              RCO_SEL_LSB  = 0;
    localparam int              RCO_SEL_W    = 4;
    localparam int              RCO_NSRC     = 16;
    // sources for which run-in-sleep has no say
    localparam logic [3:0]      RCO_SEL_NRS0 = 4'h0;
    localparam logic [3:0]      RCO_SEL_NRS1 = 4'h1;
    localparam logic [31:0]     RCO_RSVD_MSK = 32'h800044F0;
    localparam logic [14:0]     RCO_DIV_ONE  = 15'h0001;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [0:0] {
        RCO_SW_IDLE = 1'b0,
        RCO_SW_BUSY = 1'b1
    } rco_sw_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rco_apb_req_t;

    typedef struct packed {
        logic [14:0] div;
        logic [3:0]  sel;
        logic        on;
        logic        stop_in_idle;
        logic        oe;
        logic        run_in_sleep;
        logic [14:0] div_pend;
        logic [3:0]  sel_pend;
        rco_sw_t     sw;
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic        src_prev;
        logic [14:0] cnt;
        logic        clk_out;
        logic        pin;
        logic        pin_oe;
        logic        active;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rco_state_t;

    // every field resets to zero
    localparam rco_state_t      RCO_STATE_RST = '0;

endpackage

/* logic/rco_top.sv */
// reference clock output control: APB register, source select, divider,
// pin drive, idle/sleep gating and glitch-free divider switch
// assumes idle_mode/sleep_mode come from logic on pclk; source clocks are
// asynchronous and slower than pclk/2
//
// Overview of operation
// (RULE1) 15-bit divisor lives in control bits 30:16 and sets division ratio
// (RULE2) bit 15 enables the generator; resets to zero
// (RULE3) stop-in-idle bit 13 halts generator in Idle, else it keeps running
// (RULE4) pin-drive bit 12 puts the reference clock on the output pin
// (RULE5) run-in-sleep bit 11 keeps output running in Sleep, else stops it
// (RULE6) run-in-sleep ignored when source select is 0000 or 0001
// (RULE7) switch bit 9 reads one while switch runs; hardware clears it
// (RULE8) while enabled, divisor/source writes wait for the switch bit
// (RULE9) read-only bit 8 shows an active clock request
// (RULE10) software must not change divisor/source while request is active
// (RULE11) bits 31, 14, 10 and 7:4 always read zero
// (RULE12) output is source over twice divisor; divisor zero passes source
`timescale 1ns/1ps
`default_nettype none

module rco_top
    import rco_pkg::*;
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire rco_pkg::rco_apb_req_t apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // power modes and clock sources
    input  wire logic                  idle_mode,
    input  wire logic                  sleep_mode,
    input  wire logic [15:0]           src_clk_in,
    // reference clock outputs
    output logic                       ref_clk_out,
    output logic                       ref_clock_pin,
    output logic                       ref_clock_pin_oe
);
    import rco_pkg::*;

    // ****************************************
    // state
    // ****************************************
    rco_state_t  s;
    rco_state_t  n;
    logic        src_lvl;
    logic        halt;
    logic        sleep_stop;
    logic        acc;
    logic        hit;
    logic        wr;
    logic        div_last;
    logic [31:0] rd_word;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n = s;
        // sources are asynchronous: two flops before use
        n.sync1 = src_clk_in;
        n.sync2 = s.sync1;
        src_lvl = s.sync2[s.sel];
        n.src_prev = src_lvl;

        // (RULE6) source-dependent sleep gating
        sleep_stop = sleep_mode && (!s.run_in_sleep || s.sel == RCO_SEL_NRS0
                                    || s.sel == RCO_SEL_NRS1);
        // (RULE2) (RULE3) (RULE5) halt sources
        halt = !s.on || (idle_mode && s.stop_in_idle) || sleep_stop;

        // (RULE11) read word, unimplemented bits zero
        rd_word = '0;
        rd_word[RCO_DIV_LSB +: RCO_DIV_W] = s.div;
        rd_word[RCO_ON_BIT]   = s.on;
        rd_word[RCO_STOP_IN_IDLE_BIT] = s.stop_in_idle;
        rd_word[RCO_OE_BIT]   = s.oe;
        rd_word[RCO_RUN_IN_SLEEP_BIT] = s.run_in_sleep;
        // (RULE7) switch status read back
        rd_word[RCO_SWGO_BIT] = (s.sw == RCO_SW_BUSY);
        // (RULE9) request status read back
        rd_word[RCO_ACT_BIT]  = s.active;
        rd_word[RCO_SEL_LSB +: RCO_SEL_W] = s.sel;

        // apb: one wait state, answer from flops
        acc = apb_req.psel && apb_req.penable;
        hit = (apb_req.paddr == RCO_CTRL_OFF);
        wr  = acc && s.pready && apb_req.pwrite && !s.pslverr;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        if (acc && !s.pready) begin
            n.pready  = 1'b1;
            n.pslverr = !hit;
            n.prdata  = hit ? rd_word : '0;
        end

        // (RULE12) divider: toggle every div source rising edges
        div_last = (s.cnt >= s.div - RCO_DIV_ONE);
        if (halt) begin
            n.clk_out = 1'b0;
            n.cnt     = '0;
        end else if (s.div == '0) begin
            n.clk_out = src_lvl;
        end else if (src_lvl && !s.src_prev) begin
            if (div_last) begin
                n.clk_out = !s.clk_out;
                n.cnt     = '0;
            end else begin
                n.cnt = s.cnt + RCO_DIV_ONE;
            end
        end

        // (RULE7) switch completes in the low phase or while halted, so no runt pulse
        if (s.sw == RCO_SW_BUSY && (!s.clk_out || halt)) begin
            n.div = s.div_pend;
            n.sel = s.sel_pend;
            n.cnt = '0;
            n.sw  = RCO_SW_IDLE;
        end

        if (wr) begin
            // (RULE2) enable and mode bits
            n.on   = apb_req.pwdata[RCO_ON_BIT];
            n.stop_in_idle = apb_req.pwdata[RCO_STOP_IN_IDLE_BIT];
            n.oe   = apb_req.pwdata[RCO_OE_BIT];
            n.run_in_sleep = apb_req.pwdata[RCO_RUN_IN_SLEEP_BIT];
            // (RULE1) divisor and source go to the shadow first
            n.div_pend = apb_req.pwdata[RCO_DIV_LSB +: RCO_DIV_W];
            n.sel_pend = apb_req.pwdata[RCO_SEL_LSB +: RCO_SEL_W];
            // (RULE8) while running, only the switch loads new values
            if (!s.on) begin
                n.div = apb_req.pwdata[RCO_DIV_LSB +: RCO_DIV_W];
                n.sel = apb_req.pwdata[RCO_SEL_LSB +: RCO_SEL_W];
            end
            // writing one starts a switch; writing zero is ignored
            if (apb_req.pwdata[RCO_SWGO_BIT]) begin
                n.sw = RCO_SW_BUSY;
            end
        end

        // (RULE9) request active while the generator runs
        n.active = !halt;
        // (RULE4) pin drive follows the output-enable bit
        n.pin_oe = s.oe;
        n.pin    = s.oe && s.clk_out;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= RCO_STATE_RST;
        end else begin
            s <= n;
        end
    end

    assign prdata           = s.prdata;
    assign pready           = s.pready;
    assign pslverr          = s.pslverr;
    assign ref_clk_out      = s.clk_out;
    assign ref_clock_pin    = s.pin;
    assign ref_clock_pin_oe = s.pin_oe;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence apb_wait_s;
        acc && !s.pready;
    endsequence

    sequence apb_done_s;
        s.pready ##1 !s.pready;
    endsequence

    // a write in the completion cycle may restart the switch (set wins)
    sequence sw_low_s;
        s.sw == RCO_SW_BUSY && !s.clk_out && !wr;
    endsequence

    apb_ready_pulse_a: assert property (apb_wait_s |=> apb_done_s)
        else $error("pready is not a single pulse after one wait");

    rsvd_read_zero_a: assert property ( // RULE11
        (s.prdata & RCO_RSVD_MSK) == '0)
        else $error("unimplemented control bits read nonzero");

    enable_write_a: assert property ( // RULE2
        wr |=> s.on == $past(apb_req.pwdata[RCO_ON_BIT]))
        else $error("enable bit did not take written value");

    div_direct_load_a: assert property ( // RULE1
        wr && !s.on && s.sw == RCO_SW_IDLE |=>
            s.div == $past(apb_req.pwdata[RCO_DIV_LSB +: RCO_DIV_W]))
        else $error("divisor not loaded while disabled");

    div_hold_off_a: assert property ( // RULE8
        s.on && s.sw == RCO_SW_IDLE |=> $stable(s.div) && $stable(s.sel))
        else $error("divisor or source changed without a switch");

    switch_done_a: assert property ( // RULE7
        sw_low_s |=> s.sw == RCO_SW_IDLE && s.div == $past(s.div_pend))
        else $error("switch did not complete in low phase");

    idle_stop_a: assert property ( // RULE3
        idle_mode && s.stop_in_idle |=> !s.active && !s.clk_out)
        else $error("generator kept running in idle");

    sleep_stop_a: assert property ( // RULE6
        sleep_mode && (s.sel == RCO_SEL_NRS0 || s.sel == RCO_SEL_NRS1)
            |=> !s.active)
        else $error("run-in-sleep honoured for fixed source");

    sleep_run_a: assert property ( // RULE5
        s.on && sleep_mode && s.run_in_sleep && !idle_mode
            && s.sel != RCO_SEL_NRS0 && s.sel != RCO_SEL_NRS1 |=> s.active)
        else $error("output stopped in sleep with run-in-sleep set");

    request_active_a: assert property ( // RULE9
        s.on && !idle_mode && !sleep_mode |=> s.active ##1 1'b1)
        else $error("request status low while running");

    pin_release_a: assert property ( // RULE4
        !s.oe |=> !s.pin_oe && !s.pin)
        else $error("pin driven with pin-drive bit clear");

    pass_through_a: assert property ( // RULE12
        !halt && s.div == '0 |=> s.clk_out == $past(src_lvl))
        else $error("divisor zero does not pass the source");

    sequence src_rise_s;
        !halt && s.div != '0 && src_lvl && !s.src_prev;
    endsequence

    sequence reg_read_s;
        acc && !s.pready && hit;
    endsequence

    div_read_a: assert property ( // RULE1
        reg_read_s |=> s.prdata[RCO_DIV_LSB +: RCO_DIV_W] == $past(s.div))
        else $error("divisor readback differs from live value");

    busy_read_a: assert property ( // RULE7
        reg_read_s |=> s.prdata[RCO_SWGO_BIT] == $past(s.sw == RCO_SW_BUSY))
        else $error("switch busy bit readback wrong");

    active_read_a: assert property ( // RULE9
        reg_read_s |=> s.prdata[RCO_ACT_BIT] == $past(s.active))
        else $error("request status readback wrong");

    go_sets_busy_a: assert property ( // RULE7
        wr && apb_req.pwdata[RCO_SWGO_BIT] |=> s.sw == RCO_SW_BUSY)
        else $error("switch bit write did not start a switch");

    shadow_write_a: assert property ( // RULE8
        wr |=> s.div_pend == $past(apb_req.pwdata[RCO_DIV_LSB +: RCO_DIV_W])
            && s.sel_pend == $past(apb_req.pwdata[RCO_SEL_LSB +: RCO_SEL_W]))
        else $error("written divisor or source missing from shadow");

    off_quiet_a: assert property ( // RULE2
        !s.on |=> !s.clk_out && !s.active && s.cnt == '0)
        else $error("generator runs while disabled");

    idle_run_a: assert property ( // RULE3
        s.on && idle_mode && !s.stop_in_idle && !sleep_mode |=> s.active)
        else $error("generator stopped in idle with stop-in-idle clear");

    sleep_halt_a: assert property ( // RULE5
        sleep_mode && !s.run_in_sleep |=> !s.active && !s.clk_out)
        else $error("output kept running in sleep");

    pin_follow_a: assert property ( // RULE4
        s.oe |=> s.pin_oe && s.pin == $past(s.clk_out))
        else $error("pin does not carry the reference clock");

    div_wrap_a: assert property ( // RULE12
        src_rise_s ##0 div_last |=> s.clk_out != $past(s.clk_out)
            && s.cnt == '0)
        else $error("divider did not toggle at terminal count");

    div_count_a: assert property ( // RULE12
        src_rise_s ##0 (!div_last && s.sw == RCO_SW_IDLE) |=>
            s.cnt == $past(s.cnt) + RCO_DIV_ONE)
        else $error("divider count did not advance on source edge");

    div_steady_a: assert property ( // RULE12
        !halt && s.div != '0 && !(src_lvl && !s.src_prev) |=> $stable(s.clk_out))
        else $error("divided output changed without a source edge");

    bad_addr_a: assert property (
        acc && !s.pready && !hit |=> s.pslverr && s.prdata == '0)
        else $error("unmapped access not answered with an error");

    ready_idle_a: assert property (
        !acc |=> !s.pready)
        else $error("pready raised without an access phase");

endmodule

`default_nettype wire

/* verif/rco_src_model.sv */
// source clock partner: sixteen free-running oscillators
// assumes pclk is the bench clock; source i has a half period of 3+i
// pclk cycles, so every source stays well under pclk/2
`timescale 1ns/1ps
`default_nettype none

module rco_src_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // sources
    output var  logic [15:0] src_clk_in
);
    for (genvar i = 0; i < 16; i++) begin : g_src
        int c;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                c <= 0;
                src_clk_in[i] <= 1'b0;
            end else if (c == 2 + i) begin
                c <= 0;
                src_clk_in[i] <= ~src_clk_in[i];
            end else begin
                c <= c + 1;
            end
        end
    end
endmodule

`default_nettype wire

/* verif/tb_reference_clock_output_control.sv */
// self-checking bench for the reference clock control
// assumes rco_src_model gives source i a half period of 3+i cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin mismatches++; \
    $display("Error t=%0t got %h exp %h", $time, g, x); end end

module tb_reference_clock_output_control;
    import rco_pkg::*;
    logic         pclk, presetn, idle_mode, sleep_mode, e, hp;
    logic         pready, pslverr, ref_clk_out, ref_clock_pin, ref_clock_pin_oe;
    logic [15:0]  src_clk_in;
    logic [31:0]  prdata, q, d, cf;
    rco_apb_req_t req;
    int           seed = 72224, mismatches = 0, check_count = 0, cyc = 0, p;
    logic [8:0]   md [6] = '{9'h144, 9'h105, 9'h084, 9'h0A5, 9'h0A0, 9'h0A2};
    logic         im, sm, si, rs, x, oe;
    logic [3:0]   s;
    logic [14:0]  dv;

    rco_top rco_top_i (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .idle_mode(idle_mode), .sleep_mode(sleep_mode),
        .src_clk_in(src_clk_in), .ref_clk_out(ref_clk_out),
        .ref_clock_pin(ref_clock_pin), .ref_clock_pin_oe(ref_clock_pin_oe));
    rco_src_model rco_src_model_i (.pclk(pclk), .presetn(presetn),
        .src_clk_in(src_clk_in));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ****
    // helpers
    // ****
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] wd);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        req <= '0;
    endtask

    // period between the second and third rising output edge
    task automatic meas(output int n, output logic h);
        int c, r;
        logic pv;
        c = 0; r = 0; n = 0; h = 1'b0; pv = 1'b1;
        while (r < 3 && c < 2000) begin
            @(posedge pclk);
            c++;
            h |= (ref_clock_pin === 1'b1);
            if (ref_clk_out === 1'b1 && !pv) begin
                r++;
                if (r == 2) n = -c;
                if (r == 3) n += c;
            end
            pv = ref_clk_out;
        end
    endtask

    function automatic int exp_per(input logic [14:0] n, input logic [3:0] sl);
        return (n == 0) ? 2 * (3 + sl) : 4 * n * (3 + sl);
    endfunction

    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict;
        end
    end

    // ****
    // sequence
    // ****
    initial begin
        req = '0; idle_mode = 1'b0; sleep_mode = 1'b0; presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        xfer(0, 12'h000, 32'h0);
        `CHK(q, 32'h0)
        repeat (8) begin
            d = $random(seed);
            d[15] = 1'b0;
            xfer(1, 12'h000, d);
            xfer(0, 12'h000, 32'h0);
            `CHK(q, d & ~RCO_RSVD_MSK & ~32'h0000_8300)
        end
        xfer(1, 12'h004, 32'hFFFF_FFFF);
        xfer(0, 12'h004, 32'h0);
        `CHK({e, q}, {1'b1, 32'h0})
        $display("register test done");
        repeat (6) begin
            dv = 15'($unsigned($random(seed)) % 4);
            s = 4'($random(seed));
            oe = 1'($random(seed));
            cf = (32'(dv) << 16) | (32'(oe) << 12) | 32'(s);
            xfer(1, 12'h000, cf);
            xfer(1, 12'h000, cf | 32'h8000);
            meas(p, hp);
            `CHK(p, exp_per(dv, s))
            `CHK({ref_clock_pin_oe, hp}, {oe, oe})
            // switch off with divisor and source unchanged
            xfer(1, 12'h000, cf);
        end
        $display("divider test done");
        foreach (md[i]) begin
            {im, sm, si, rs, s, x} = md[i];
            cf = (32'(si) << 13) | (32'(rs) << 11) | 32'(s) | 32'h0001_0000;
            xfer(1, 12'h000, cf);
            xfer(1, 12'h000, cf | 32'h8000);
            idle_mode <= im;
            sleep_mode <= sm;
            repeat (8) @(posedge pclk);
            xfer(0, 12'h000, 32'h0);
            `CHK(q[8], x)
            if (!x) `CHK(ref_clk_out, 1'b0)
            idle_mode <= 1'b0;
            sleep_mode <= 1'b0;
            // switch off with divisor and source unchanged
            xfer(1, 12'h000, cf);
        end
        $display("mode test done");
        xfer(1, 12'h000, 32'h0002_2003);
        xfer(1, 12'h000, 32'h0002_A003);
        idle_mode <= 1'b1;
        repeat (4) @(posedge pclk);
        // divisor and source load only through the switch bit, even while request is idle
        xfer(1, 12'h000, 32'h0005_A004);
        xfer(0, 12'h000, 32'h0);
        `CHK(q, 32'h0002_A003)
        xfer(1, 12'h000, 32'h0005_A204);
        repeat (4) @(posedge pclk);
        xfer(0, 12'h000, 32'h0);
        `CHK(q, 32'h0005_A004)
        idle_mode <= 1'b0;
        meas(p, hp);
        `CHK(p, exp_per(15'd5, 4'd4))
        $display("switch test done");
        give_verdict;
    end
endmodule

`default_nettype wire
